/* hdl/ptm_paired_timer.sv */
// Purpose: two timer pairs, each 2x16-bit or one cascaded 32-bit timer
// Assumes: control words held stable while a timer runs
// Notes: no software registers; control and status are plain ports

`timescale 1ns/1ns

module ptm_paired_timer
  import ptm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire ptm_ctrl_t pairALowControl,
  input wire ptm_ctrl_t pairAHighControl,
  input wire ptm_ctrl_t pairBLowControl,
  input wire ptm_ctrl_t pairBHighControl,
  input wire logic [TIMERS-1:0][TIMER_W-1:0] periodValue,
  input wire logic [TIMERS-1:0] extClockPin,
  input wire logic [TIMERS-1:0] gatePin,
  input wire logic idleMode,
  input wire logic sleepMode,
  input wire logic [TIMERS-1:0] flagClear,
  output logic [TIMERS-1:0][TIMER_W-1:0] counterValue,
  output logic [TIMERS-1:0] interruptFlag,
  output logic [PAIRS-1:0] converterTrigger,
  output logic [TIMERS-1:0] dmaTrigger,
  output logic [1:0] timeBaseTick
);

  typedef struct packed {
    logic [TIMERS-1:0][TIMER_W-1:0] count;
    logic [TIMERS-1:0] flag;
    logic [PAIRS-1:0] conv;
    logic [TIMERS-1:0] dma;
    logic [1:0] tb;
  } ptm_state_t;

  ptm_state_t state;
  ptm_state_t next_state;
  ptm_ctrl_t ctrl [TIMERS];
  logic [1:0] rstPipe;
  logic rstSyncN;
  logic [TIMERS-1:0] tickEff;
  logic [TIMERS-1:0] gateFallEff;
  logic [TIMERS-1:0] matchEv;
  logic [2*TIMER_W-1:0] wide;
  logic [2*TIMER_W-1:0] sum;

  function automatic logic ptm_hits(input logic [TIMER_W-1:0] c,
    input logic [TIMER_W-1:0] p);
    return c == p;
  endfunction

  // internal clock halts in sleep, so only the external counter keeps going
  function automatic logic ptm_runs(input ptm_ctrl_t c, input logic idle,
    input logic sleep);
    return c.enable & ~(idle & c.stopInIdle) & ~(sleep & ~c.extClock);
  endfunction

  // ************************************************************
  // reset release
  // ************************************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstPipe <= RST_PIPE_RESET;
    end
    else
    begin
      rstPipe <= {rstPipe[0], 1'h1};
    end
  end

  assign rstSyncN = rstPipe[1];

  // ************************************************************
  // prescalers
  // ************************************************************
  assign ctrl[0] = pairALowControl;
  assign ctrl[1] = pairAHighControl;
  assign ctrl[2] = pairBLowControl;
  assign ctrl[3] = pairBHighControl;

  ptm_tick_if tickLink [TIMERS] ();

  genvar gi;
  generate
    for (gi = 0; gi < TIMERS; gi++)
    begin : g_pre
      // high half of a cascaded pair is held stopped, its control unused
      if (gi % 2 == 1)
      begin : g_hi
        assign tickLink[gi].run = ptm_runs(ctrl[gi], idleMode, sleepMode)
          & ~ctrl[gi-1].wide32;
      end
      else
      begin : g_lo
        assign tickLink[gi].run = ptm_runs(ctrl[gi], idleMode, sleepMode);
      end
      assign tickLink[gi].gateMode = ctrl[gi].gateMode;
      assign tickLink[gi].extSel = ctrl[gi].extClock;
      assign tickLink[gi].prescale = ctrl[gi].prescale;

      ptm_prescaler u_pre (
        .sys_clk(sys_clk),
        .rstSyncN(rstSyncN),
        .link(tickLink[gi]),
        .extClk(extClockPin[gi]),
        .gateIn(gatePin[gi])
      );

      if (gi % 2 == 1)
      begin : g_hisel
        assign tickEff[gi] = ctrl[gi-1].wide32 ? tickLink[gi-1].tick
          : tickLink[gi].tick;
        assign gateFallEff[gi] = ctrl[gi-1].wide32 ? 1'h0 : tickLink[gi].gateFall;
      end
      else
      begin : g_losel
        assign tickEff[gi] = tickLink[gi].tick;
        assign gateFallEff[gi] = tickLink[gi].gateFall;
      end
    end
  endgenerate

  // ************************************************************
  // counting
  // ************************************************************
  always_comb
  begin
    next_state = state;
    matchEv = FLAG_RESET;
    wide = {state.count[1], state.count[0]};
    sum = wide;
    for (int p = 0; p < PAIRS; p++)
    begin
      if (ctrl[2*p].wide32)
      begin
        wide = {state.count[2*p+1], state.count[2*p]};
        sum = wide + 32'h00000001;
        if (tickEff[2*p])
        begin
          if (wide == {periodValue[2*p+1], periodValue[2*p]})
          begin
            next_state.count[2*p] = COUNT_RESET;
            next_state.count[2*p+1] = COUNT_RESET;
            matchEv[2*p+1] = 1'h1;
          end
          else
          begin
            // carry out of the low word lands in the high word
            next_state.count[2*p] = sum[TIMER_W-1:0];
            next_state.count[2*p+1] = sum[2*TIMER_W-1:TIMER_W];
          end
        end
        if (gateFallEff[2*p])
        begin
          matchEv[2*p+1] = 1'h1;
        end
      end
      else
      begin
        for (int h = 2*p; h < 2*p+2; h++)
        begin
          if (tickEff[h])
          begin
            if (ptm_hits(state.count[h], periodValue[h]))
            begin
              next_state.count[h] = COUNT_RESET;
              matchEv[h] = 1'h1;
            end
            else
            begin
              next_state.count[h] = state.count[h] + 16'h0001;
            end
          end
          if (gateFallEff[h])
          begin
            matchEv[h] = 1'h1;
          end
        end
      end
      next_state.conv[p] = matchEv[2*p+1];
    end
    // a new event outweighs a clear in the same cycle
    next_state.flag = (state.flag & ~flagClear) | matchEv;
    next_state.dma = matchEv;
    next_state.tb = tickEff[1:0];
  end

  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      state <= '{count: {TIMERS{COUNT_RESET}}, flag: FLAG_RESET, conv: 2'h0,
        dma: FLAG_RESET, tb: 2'h0};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign counterValue = state.count;
  assign interruptFlag = state.flag;
  assign converterTrigger = state.conv;
  assign dmaTrigger = state.dma;
  assign timeBaseTick = state.tb;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstSyncN);

  lowFlagQuiet_a: assert property (
    ctrl[0].wide32 && !interruptFlag[0] |=> !interruptFlag[0])
    else $error("low flag set in cascaded mode");

  carryIntoHigh_a: assert property (
    ctrl[0].wide32 && tickEff[0] && counterValue[0] == COUNT_ALL_ONES
    && {counterValue[1], counterValue[0]} != {periodValue[1], periodValue[0]}
    |=> counterValue[1] == $past(counterValue[1]) + 16'h0001
    && counterValue[0] == COUNT_RESET)
    else $error("high word missed the carry");

  highHold_a: assert property (
    ctrl[0].wide32 && !tickEff[0] |=> counterValue[1] == $past(counterValue[1]))
    else $error("high word moved without low tick");

  wrapToZero_a: assert property (
    !ctrl[2].wide32 && tickEff[2] && counterValue[2] == periodValue[2]
    |=> counterValue[2] == COUNT_RESET && interruptFlag[2])
    else $error("16-bit period match mishandled");

  match32_a: assert property (
    ctrl[2].wide32 && tickEff[2]
    && {counterValue[3], counterValue[2]} == {periodValue[3], periodValue[2]}
    |=> interruptFlag[3] && counterValue[3] == COUNT_RESET
    && counterValue[2] == COUNT_RESET)
    else $error("32-bit period match mishandled");

  convSource_a: assert property (
    converterTrigger[0] |-> $past(matchEv[1]))
    else $error("converter trigger without high match");

  dmaPulse_a: assert property (
    matchEv[0] |=> dmaTrigger[0] && interruptFlag[0])
    else $error("dma trigger missing");

  setWins_a: assert property (
    flagClear[1] && matchEv[1] |=> interruptFlag[1])
    else $error("clear beat a new event");

  splitStep_a: assert property (
    !ctrl[0].wide32 && tickEff[1] && counterValue[1] != periodValue[1]
    |=> counterValue[1] == $past(counterValue[1]) + 16'h0001)
    else $error("split high timer failed to count");

  timeBase_a: assert property (
    tickEff[0] |=> timeBaseTick[0])
    else $error("time base tick missing");

  idleStop_a: assert property (
    (idleMode && ctrl[1].stopInIdle && !ctrl[0].wide32) [*2]
    |-> counterValue[1] == $past(counterValue[1]))
    else $error("timer ran in idle");

  convLowQuiet_a: assert property (
    !ctrl[0].wide32 && matchEv[0] && !matchEv[1] |=> !converterTrigger[0])
    else $error("low timer pulsed converter");

  highEvents_a: assert property (
    matchEv[3] |=> dmaTrigger[3] && converterTrigger[1])
    else $error("pair B high event lost");

  gateFlag_a: assert property (
    !ctrl[0].wide32 && gateFallEff[0] |=> interruptFlag[0] && dmaTrigger[0])
    else $error("gate close event lost");

  highTimeBase_a: assert property (
    tickEff[1] |=> timeBaseTick[1])
    else $error("high time base tick missing");

  cover32Match_c: cover property (ctrl[0].wide32 ##1 interruptFlag[1]);
  coverConv_c: cover property (converterTrigger[1]);
  coverGate_c: cover property (gateFallEff[2] ##1 interruptFlag[2]);
  coverCarry_c: cover property (ctrl[0].wide32 && tickEff[0]
    && counterValue[0] == COUNT_ALL_ONES);

endmodule

/* hdl/ptm_pkg.sv */
// Purpose: shared constants and types for the paired timer block
// Assumes: four 16-bit timers grouped as two pairs
// Notes: prescaler ratios are fixed at 1, 8, 64 and 256

package ptm_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int TIMER_W = 16;
  localparam int TIMERS = 4;
  localparam int PAIRS = 2;

  // ************************************************************
  // prescaler selection and terminal counts
  // ************************************************************
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV8 = 2'h1;
  localparam logic [1:0] PRE_DIV64 = 2'h2;
  localparam logic [1:0] PRE_DIV256 = 2'h3;
  localparam logic [7:0] PRE_END_1 = 8'h00;
  localparam logic [7:0] PRE_END_8 = 8'h07;
  localparam logic [7:0] PRE_END_64 = 8'h3F;
  localparam logic [7:0] PRE_END_256 = 8'hFF;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [TIMER_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [TIMER_W-1:0] COUNT_ALL_ONES = 16'hFFFF;
  localparam logic [TIMERS-1:0] FLAG_RESET = 4'h0;
  localparam logic [1:0] RST_PIPE_RESET = 2'h0;

  // ************************************************************
  // per-timer control word
  // ************************************************************
  typedef struct packed {
    logic enable;
    logic gateMode;
    logic extClock;
    logic stopInIdle;
    logic [1:0] prescale;
    logic wide32;
  } ptm_ctrl_t;

  function automatic logic [7:0] ptm_pre_end(input logic [1:0] sel);
    case (sel)
      PRE_DIV1: return PRE_END_1;
      PRE_DIV8: return PRE_END_8;
      PRE_DIV64: return PRE_END_64;
      default: return PRE_END_256;
    endcase
  endfunction

endpackage

/* hdl/ptm_tick_if.sv */
// Purpose: count-enable link between timer core and one prescaler
// Assumes: single clock domain
// Notes: gateFall is a one-cycle pulse; tick is a count enable, high every cycle at divide by 1 on the ungated internal clock

`timescale 1ns/1ns

interface ptm_tick_if;
  logic run;
  logic gateMode;
  logic extSel;
  logic [1:0] prescale;
  logic tick;
  logic gateFall;

  modport ctl (output run, output gateMode, output extSel, output prescale,
    input tick, input gateFall);
  modport pre (input run, input gateMode, input extSel, input prescale,
    output tick, output gateFall);
endinterface

/* hdl/ptm_prescaler.sv */
// Purpose: clock source select, gate and prescaler for one timer
// Assumes: external clock and gate pins already synchronous
// Notes: divider clears whenever the timer is stopped

`timescale 1ns/1ns

module ptm_prescaler
  import ptm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstSyncN,
  ptm_tick_if.pre link,
  input wire logic extClk,
  input wire logic gateIn
);

  typedef struct packed {
    logic extSample;
    logic gateSample;
    logic [7:0] divCount;
  } ptm_pre_state_t;

  ptm_pre_state_t state;
  ptm_pre_state_t next_state;
  logic base;
  logic extRise;
  logic gateFallRaw;
  logic atEnd;

  // ************************************************************
  // source select and divider
  // ************************************************************
  always_comb
  begin
    next_state = state;
    extRise = extClk & ~state.extSample;
    gateFallRaw = ~gateIn & state.gateSample;
    next_state.extSample = extClk;
    next_state.gateSample = gateIn;
    // >= so a smaller ratio chosen mid-count cannot strand the divider
    atEnd = state.divCount >= ptm_pre_end(link.prescale);
    if (link.extSel)
    begin
      base = extRise;
    end
    else if (link.gateMode)
    begin
      base = gateIn;
    end
    else
    begin
      base = 1'h1;
    end
    if (!link.run)
    begin
      next_state.divCount = DIV_RESET;
    end
    else if (base)
    begin
      if (atEnd)
      begin
        next_state.divCount = DIV_RESET;
      end
      else
      begin
        next_state.divCount = state.divCount + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      state <= '{extSample: 1'h0, gateSample: 1'h0, divCount: DIV_RESET};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign link.tick = link.run & base & atEnd;
  assign link.gateFall = link.run & link.gateMode & ~link.extSel & gateFallRaw;

  // ************************************************************
  // checks
  // ************************************************************
  prescaleSpan_a: assert property (@(posedge sys_clk) disable iff (!rstSyncN)
    link.tick && !link.extSel && !link.gateMode && link.prescale == PRE_DIV8
    |=> !link.tick [*7])
    else $error("divide by eight ticked early");

  coverDiv8_c: cover property (@(posedge sys_clk) disable iff (!rstSyncN)
    link.tick && link.prescale == PRE_DIV8 ##8 link.tick);

endmodule

/* sim/ptm_event_sink.sv */
// Purpose: far-side model counting converter and DMA trigger pulses
// Assumes: triggers are one-cycle pulses on sys_clk
// Notes: counts wrap at 255, enough for short scenarios

`timescale 1ns/1ns

module ptm_event_sink
  import ptm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [PAIRS-1:0] converterTrigger,
  input wire logic [TIMERS-1:0] dmaTrigger,
  output logic [PAIRS-1:0][7:0] convCount,
  output logic [TIMERS-1:0][7:0] dmaCount
);
  // ************************************************************
  // pulse counters
  // ************************************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      convCount <= '0;
      dmaCount <= '0;
    end
    else
    begin
      for (int i = 0; i < PAIRS; i++)
        convCount[i] <= convCount[i] + 8'(converterTrigger[i]);
      for (int i = 0; i < TIMERS; i++)
        dmaCount[i] <= dmaCount[i] + 8'(dmaTrigger[i]);
    end
  end
endmodule

/* sim/testbench.sv */
// Purpose: self-checking bench for the paired timer block
// Assumes: inputs change 2 ns after each rising edge
// Notes: the 32-bit wrap case alone runs about 65k cycles

`timescale 1ns/1ns

module testbench
  import ptm_pkg::*;
();
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  ptm_ctrl_t aLo, aHi, bLo, bHi;
  logic [TIMERS-1:0][TIMER_W-1:0] periodValue, counterValue;
  logic [TIMERS-1:0] extClockPin, gatePin, flagClear, interruptFlag, dmaTrigger;
  logic idleMode, sleepMode;
  logic [PAIRS-1:0] converterTrigger;
  logic [1:0] timeBaseTick;
  logic [PAIRS-1:0][7:0] convCount;
  logic [TIMERS-1:0][7:0] dmaCount;
  int failCount = 0;
  int numChecks = 0;

  // ************************************************************
  // clock and instances
  // ************************************************************
  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end

  ptm_paired_timer ptm_paired_timer_inst (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pairALowControl(aLo),
    .pairAHighControl(aHi),
    .pairBLowControl(bLo),
    .pairBHighControl(bHi),
    .periodValue(periodValue),
    .extClockPin(extClockPin),
    .gatePin(gatePin),
    .idleMode(idleMode),
    .sleepMode(sleepMode),
    .flagClear(flagClear),
    .counterValue(counterValue),
    .interruptFlag(interruptFlag),
    .converterTrigger(converterTrigger),
    .dmaTrigger(dmaTrigger),
    .timeBaseTick(timeBaseTick)
  );

  ptm_event_sink ptm_event_sink_inst (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .converterTrigger(converterTrigger),
    .dmaTrigger(dmaTrigger),
    .convCount(convCount),
    .dmaCount(dmaCount)
  );

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wait_flag(input int idx, input int limit, input string what);
    for (int i = 0; i < limit && interruptFlag[idx] !== 1'h1; i++)
      step(1);
    if (interruptFlag[idx] !== 1'h1)
    begin
      check(what, 32'h0, 32'h1);
      tallyAndFinish();
    end
  endtask

  function automatic ptm_ctrl_t mk(input logic en, input logic gt, input logic ex,
    input logic [1:0] pre, input logic w32);
    ptm_ctrl_t c;
    c.enable = en;
    c.gateMode = gt;
    c.extClock = ex;
    c.stopInIdle = 1'h0;
    c.prescale = pre;
    c.wide32 = w32;
    return c;
  endfunction

  // full reset between scenarios so counts start from zero
  task automatic restart(input int n);
    reset_n = 1'h0;
    aLo = '0;
    aHi = '0;
    bLo = '0;
    bHi = '0;
    periodValue = '0;
    extClockPin = '0;
    gatePin = '0;
    idleMode = 1'h0;
    sleepMode = 1'h0;
    flagClear = '0;
    step(n);
    reset_n = 1'h1;
    step(3);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic s_split16();
    restart(2);
    periodValue[0] = 16'h0002;
    periodValue[1] = 16'h0003;
    aLo = mk(1'h1, 1'h0, 1'h0, PRE_DIV1, 1'h0);
    aHi = mk(1'h1, 1'h0, 1'h0, PRE_DIV1, 1'h0);
    step(1);
    check("cnt0", 32'(counterValue[0]), 32'h1);
    check("cnt1", 32'(counterValue[1]), 32'h1);
    check("baseTick", 32'(timeBaseTick), 32'h3);
    wait_flag(0, 8, "flag0");
    check("cnt0 wrap", 32'(counterValue[0]), 32'h0);
    check("dma0", 32'(dmaTrigger[0]), 32'h1);
    check("conv low", 32'(convCount[0]), 32'h0);
    wait_flag(1, 8, "flag1");
    check("cnt1 wrap", 32'(counterValue[1]), 32'h0);
    step(1);
    check("conv high", 32'(convCount[0]), 32'h1);
    check("dma1", 32'(dmaCount[1]), 32'h1);
    aLo = '0;
    flagClear = 4'h1;
    step(1);
    check("flag0 clr", 32'(interruptFlag[0]), 32'h0);
    aHi.stopInIdle = 1'h1;
    idleMode = 1'h1;
    step(3);
    check("idle hold", 32'(counterValue[1]), 32'h2);
  endtask

  // high word control deliberately disabled: counting must follow the low word
  task automatic s_wide32();
    restart(2);
    periodValue[0] = 16'h0003;
    periodValue[1] = 16'h0001;
    aHi = mk(1'h0, 1'h1, 1'h1, PRE_DIV256, 1'h0);
    aLo = mk(1'h1, 1'h0, 1'h0, PRE_DIV1, 1'h1);
    for (int i = 0; i < 70000 && counterValue[1] !== 16'h0001; i++)
      step(1);
    check("hi after wrap", 32'(counterValue[1]), 32'h1);
    if (counterValue[1] !== 16'h0001)
      tallyAndFinish();
    check("lo after wrap", 32'(counterValue[0]), 32'h0);
    wait_flag(1, 8, "flag32");
    check("lo match", 32'(counterValue[0]), 32'h0);
    check("hi match", 32'(counterValue[1]), 32'h0);
    check("lo flag", 32'(interruptFlag[0]), 32'h0);
    step(1);
    check("conv32", 32'(convCount[0]), 32'h1);
  endtask

  task automatic s_ext_sleep();
    restart(2);
    periodValue[2] = 16'h0064;
    periodValue[3] = 16'h0002;
    bLo = mk(1'h1, 1'h0, 1'h1, PRE_DIV1, 1'h0);
    bHi = mk(1'h1, 1'h0, 1'h0, PRE_DIV1, 1'h0);
    sleepMode = 1'h1;
    for (int i = 0; i < 3; i++)
    begin
      extClockPin[2] = 1'h1;
      step(1);
      extClockPin[2] = 1'h0;
      step(1);
    end
    check("ext cnt", 32'(counterValue[2]), 32'h3);
    check("sleep hold", 32'(counterValue[3]), 32'h0);
    sleepMode = 1'h0;
    wait_flag(3, 8, "flag3");
    step(1);
    check("conv B", 32'(convCount[1]), 32'h1);
    check("dma3", 32'(dmaCount[3]), 32'h1);
  endtask

  // divide by 8 gives ticks at cycles 7 and 15, so 21 cycles lands on two
  task automatic s_pre_gate();
    restart(2);
    periodValue[0] = 16'h00FF;
    periodValue[3] = 16'h00FF;
    bHi = mk(1'h1, 1'h0, 1'h0, PRE_DIV8, 1'h0);
    aLo = mk(1'h1, 1'h1, 1'h0, PRE_DIV1, 1'h0);
    step(5);
    check("gate low", 32'(counterValue[0]), 32'h0);
    gatePin[0] = 1'h1;
    step(4);
    check("gate cnt", 32'(counterValue[0]), 32'h4);
    gatePin[0] = 1'h0;
    wait_flag(0, 4, "gate flag");
    step(11);
    check("div8", 32'(counterValue[3]), 32'h2);
  endtask

  initial
  begin
    restart(10);
    s_split16();
    s_wide32();
    s_ext_sleep();
    s_pre_gate();
    tallyAndFinish();
  end
endmodule
